// ==== rtl/frqp_pkg.sv ====
// Overview of operation
// RULE1 - four over, four under stages, each enabled
// RULE2 - frequency from one of three 5 ms references
// RULE3 - over above setting, under below setting
// RULE4 - release needs 20 mHz return past pickup
// RULE5 - pickups default 51/49 Hz, 0.01 Hz steps
// RULE6 - under stages blocked by low voltage, zero disables
// RULE7 - per-group use flag, default no
// RULE8 - static enable, disabled stage outputs nothing
// RULE9 - node mode On/Blocked/Test/TestBlocked/Off
// RULE10 - per-stage forced status overrides computed one; a forced Normal leaves the computed status shown
// RULE11 - definite time delay only
// RULE12 - group switch applied while running
// RULE13 - mode, enable, forcing independent of group
// RULE14 - read-only condition Normal/Start/Trip/Blocked
// RULE15 - read-only measured to pickup ratio
// RULE16 - read-only expected operating time, 5 ms units
// RULE17 - signed remaining time while counting
// RULE18 - block at pickup gives blocked, not start
// RULE19 - time-stamped event records, last twelve kept
// RULE20 - delay counter starts, trips, clears on release
package frqp_pkg;

    // sizes
    localparam int NUM_STAGES = 8;
    localparam int NUM_GROUPS = 8;
    localparam int FREQ_W     = 14;
    localparam int VOLT_W     = 14;
    localparam int DELAY_W    = 19;
    localparam int ADDR_W     = 12;
    localparam int LOG_DEPTH  = 12;

    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_MS = 5;
    localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    // thresholds in 0.01 Hz, voltage in 0.01 %Un
    localparam logic [13:0] HYST_CENTIHZ   = 14'h0002;
    localparam logic [13:0] OVER_PICKUP_RST  = 14'h13EC;
    localparam logic [13:0] UNDER_PICKUP_RST = 14'h1324;
    localparam logic [18:0] DELAY_RST      = 19'h00008;
    localparam logic [13:0] UV_BLOCK_RST   = 14'h0000;
    localparam logic [23:0] RATIO_SCALE    = 24'h0003E8;
    localparam logic [23:0] RATIO_MAX      = 24'h004E20;

    // register offsets
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_ENABLE = 12'h004;
    localparam logic [11:0] ADDR_FORCE  = 12'h008;
    localparam logic [11:0] ADDR_UVBLK  = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_FREQ   = 12'h014;
    localparam logic [11:0] ADDR_EVCNT  = 12'h018;
    localparam logic [3:0]  PAGE_STAGE  = 4'h1;
    localparam logic [3:0]  PAGE_LOG    = 4'h8;
    localparam logic        PAGE_GROUP  = 1'b1;

    // field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_REF_LSB   = 4;
    localparam int CTRL_GROUP_LSB = 8;
    localparam int CTRL_FORCE_BIT = 12;
    localparam int CFG_USED_BIT   = 31;
    localparam logic [31:0] CTRL_RST = 32'h00000000;

    typedef enum logic [2:0] {
        MODE_ON      = 3'h0,
        MODE_BLOCKED = 3'h1,
        MODE_TEST    = 3'h2,
        MODE_TESTBLK = 3'h3,
        MODE_OFF     = 3'h4
    } frqp_mode_type;

    typedef enum logic [1:0] {
        COND_NORMAL  = 2'h0,
        COND_START   = 2'h1,
        COND_TRIP    = 2'h2,
        COND_BLOCKED = 2'h3
    } frqp_cond_type;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_SCAN = 2'b10
    } frqp_seq_type;

endpackage

// ==== rtl/frqp_stages.sv ====
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module frqp_stages
    import frqp_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    // measurements
    input  wire logic [FREQ_W-1:0] freqRef1,
    input  wire logic [FREQ_W-1:0] freqRef2,
    input  wire logic [FREQ_W-1:0] freqRef3,
    input  wire logic [VOLT_W-1:0] voltage,
    input  wire logic [7:0]        blockIn,
    // stage status
    output logic [7:0]             startOut,
    output logic [7:0]             tripOut,
    output logic [7:0]             blockedOut,
    output logic                   testMode,
    output logic                   eventPulse
);

    // reset release
    logic rstMeta;
    logic rstSyncN;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // settings table index from group and stage
    function automatic logic [5:0] cfgIndex(input logic [2:0] grp,
                                            input logic [2:0] stg);
        cfgIndex = {grp, stg};
    endfunction

    // static settings
    logic [31:0]       ctrl;
    logic [7:0]        enable;
    logic [15:0]       forcedCond;
    logic [VOLT_W-1:0] uvSet;
    // group settings
    logic [FREQ_W-1:0]  thrMem   [0:63];
    logic [DELAY_W-1:0] delayMem [0:63];
    logic [63:0]        usedMem;
    // stage state
    logic [7:0]         pickedUp;
    logic [DELAY_W-1:0] count    [0:7];
    logic [14:0]        ratioMem [0:7];
    logic [19:0]        remainMem[0:7];
    // event log
    logic [31:0] logStamp [0:LOG_DEPTH-1];
    logic [31:0] logInfo  [0:LOG_DEPTH-1];
    logic [3:0]  logPtr;
    logic [31:0] eventTotal;
    logic [31:0] tickStamp;

    frqp_mode_type mode;
    logic [2:0]    group;
    logic [1:0]    refSel;
    logic          forceEn;
    assign mode    = frqp_mode_type'(ctrl[CTRL_MODE_LSB +: 3]);
    assign refSel  = ctrl[CTRL_REF_LSB +: 2];
    assign group   = ctrl[CTRL_GROUP_LSB +: 3];
    assign forceEn = ctrl[CTRL_FORCE_BIT];

    // 5 ms time base
    logic [31:0] tickCnt;
    logic        tick;
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            tickCnt   <= 32'h00000000;
            tick      <= 1'b0;
            tickStamp <= 32'h00000000;
        end else if (tickCnt == 32'(TICK_CYCLES_P - 1)) begin
            tickCnt   <= 32'h00000000;
            tick      <= 1'b1;
            tickStamp <= tickStamp + 32'h00000001;
        end else begin
            tickCnt <= tickCnt + 32'h00000001;
            tick    <= 1'b0;
        end
    end

    // scan sequencer: one stage per cycle after each tick
    frqp_seq_type seqState;
    logic [2:0]   idx;
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            seqState <= SEQ_IDLE;
            idx      <= 3'h0;
        end else begin
            case (seqState)
                SEQ_IDLE: begin
                    idx <= 3'h0;
                    if (tick) begin
                        seqState <= SEQ_SCAN;
                    end
                end
                SEQ_SCAN: begin
                    idx <= idx + 3'h1;
                    if (idx == 3'h7) begin
                        seqState <= SEQ_IDLE;
                    end
                end
                default: seqState <= SEQ_IDLE;
            endcase
        end
    end
    logic scan;
    assign scan = (seqState == SEQ_SCAN);

    // reference selection, refreshed once per tick
    logic [FREQ_W-1:0] freq;
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            freq <= 14'h0000;
        end else if (tick) begin
            case (refSel)                                // RULE2
                2'h1:    freq <= freqRef2;
                2'h2:    freq <= freqRef3;
                default: freq <= freqRef1;
            endcase
        end
    end

    // stage evaluation for the scanned stage
    logic [FREQ_W-1:0]  thr;
    logic [DELAY_W-1:0] dly;
    logic               used;
    logic               isUnder;
    logic               run;
    logic               pick;
    logic               blk;
    logic [DELAY_W-1:0] next_count;
    logic [2:0]         next_flags;
    logic [2:0]         shown;
    logic [23:0]        ratioFull;
    always_comb begin
        thr  = thrMem[cfgIndex(group, idx)];            // RULE12
        dly  = delayMem[cfgIndex(group, idx)];
        used = usedMem[cfgIndex(group, idx)];
        isUnder = idx[2];                                // RULE1
        run  = enable[idx] && used && mode != MODE_OFF;  // RULE7 RULE8 RULE9
        if (isUnder) begin
            pick = pickedUp[idx]                         // RULE4
                 ? ({1'b0, freq} < {1'b0, thr} + {1'b0, HYST_CENTIHZ})
                 : (freq < thr);                         // RULE3
        end else begin
            pick = pickedUp[idx]                         // RULE4
                 ? ({1'b0, freq} + {1'b0, HYST_CENTIHZ} > {1'b0, thr})
                 : (freq > thr);                         // RULE3
        end
        pick = pick && run;
        blk = blockIn[idx] || mode == MODE_BLOCKED
           || mode == MODE_TESTBLK                       // RULE9
           || (isUnder && uvSet != 14'h0000 && voltage < uvSet); // RULE6
        // flags are {blocked, trip, start}
        next_count = count[idx];
        next_flags = 3'b000;
        if (!pick) begin
            next_count = 19'h00000;                      // RULE20
        end else if (blk) begin
            next_count = 19'h00000;                      // RULE18
            next_flags = 3'b100;
        end else begin
            if (count[idx] != {DELAY_W{1'b1}}) begin
                next_count = count[idx] + 19'h00001;     // RULE20
            end
            next_flags = {1'b0, next_count >= dly, 1'b1}; // RULE11
        end
        shown = next_flags;
        if (forceEn && enable[idx]) begin                // RULE10 RULE13
            case (forcedCond[2*idx +: 2])
                COND_START:   shown = 3'b001;
                COND_TRIP:    shown = 3'b011;
                COND_BLOCKED: shown = 3'b100;
                default:      shown = next_flags;
            endcase
        end
        ratioFull = (thr == 14'h0000) ? RATIO_MAX
                  : 24'(({10'h000, freq} * RATIO_SCALE) / {10'h000, thr});
    end

    // stage state update
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pickedUp <= 8'h00;
            for (int i = 0; i < NUM_STAGES; i++) begin
                count[i]     <= 19'h00000;
                ratioMem[i]  <= 15'h0000;
                remainMem[i] <= 20'h00000;
            end
        end else if (scan) begin
            pickedUp[idx] <= pick;
            count[idx]    <= next_count;
            ratioMem[idx] <= (ratioFull > RATIO_MAX)     // RULE15
                           ? RATIO_MAX[14:0] : ratioFull[14:0];
            remainMem[idx] <= (next_flags[0] && !next_flags[1]) // RULE17
                            ? {1'b0, dly} - {1'b0, next_count}
                            : 20'h00000;
        end
    end

    // published status, change of any flag is an event
    logic eventNow;
    assign eventNow = scan
        && shown != {blockedOut[idx], tripOut[idx], startOut[idx]};
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            startOut   <= 8'h00;
            tripOut    <= 8'h00;
            blockedOut <= 8'h00;
            eventPulse <= 1'b0;
            testMode   <= 1'b0;
        end else begin
            eventPulse <= eventNow;
            testMode   <= (mode == MODE_TEST) || (mode == MODE_TESTBLK);
            if (scan) begin
                startOut[idx]   <= shown[0];
                tripOut[idx]    <= shown[1];
                blockedOut[idx] <= shown[2];
            end
        end
    end

    // event log ring and cumulative counter
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            logPtr     <= 4'h0;
            eventTotal <= 32'h00000000;
            for (int i = 0; i < LOG_DEPTH; i++) begin
                logStamp[i] <= 32'h00000000;
                logInfo[i]  <= 32'h00000000;
            end
        end else begin
            if (eventNow) begin                          // RULE19
                logStamp[logPtr] <= tickStamp;
                logInfo[logPtr]  <= {2'h0, freq, 5'h00, idx, 1'b0,
                    blockedOut[idx], tripOut[idx], startOut[idx],
                    1'b0, shown};
                logPtr <= (logPtr == 4'(LOG_DEPTH - 1))
                        ? 4'h0 : logPtr + 4'h1;
            end
            // counting wins over a clear in the same cycle
            if (eventNow) begin
                eventTotal <= eventTotal + 32'h00000001;
            end else if (wr && addr == ADDR_EVCNT) begin
                eventTotal <= 32'h00000000;
            end
        end
    end

    // static settings writes
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            ctrl   <= CTRL_RST;                          // RULE9
            enable <= 8'h00;                             // RULE8
            forcedCond <= 16'h0000;                      // RULE10
            uvSet  <= UV_BLOCK_RST;                      // RULE6
        end else if (wr) begin
            case (addr)
                ADDR_CTRL:   ctrl   <= wdata & 32'h000017F7;
                ADDR_ENABLE: enable <= wdata[7:0];       // RULE1
                ADDR_FORCE:  forcedCond <= wdata[15:0];
                ADDR_UVBLK:  uvSet  <= wdata[VOLT_W-1:0];
                default:     ;
            endcase
        end
    end

    // group settings writes
    logic [5:0] wrCfg;
    assign wrCfg = cfgIndex(addr[9:7], addr[6:4]);
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            usedMem <= 64'h0000000000000000;             // RULE7
            for (int i = 0; i < 64; i++) begin
                thrMem[i]   <= (i % 8 < 4) ? OVER_PICKUP_RST
                                           : UNDER_PICKUP_RST; // RULE5
                delayMem[i] <= DELAY_RST;
            end
        end else if (wr && addr[11:10] == {1'b0, PAGE_GROUP}) begin
            if (addr[3:2] == 2'h0) begin
                thrMem[wrCfg]  <= wdata[FREQ_W-1:0];     // RULE5
                usedMem[wrCfg] <= wdata[CFG_USED_BIT];
            end else if (addr[3:2] == 2'h1) begin
                delayMem[wrCfg] <= wdata[DELAY_W-1:0];   // RULE11
            end
        end
    end

    // read port, data one cycle after the strobe
    logic [2:0] rdStage;
    logic [3:0] rdLog;
    logic [5:0] rdCfg;
    assign rdStage = addr[6:4];
    assign rdLog   = addr[6:3];
    assign rdCfg   = cfgIndex(addr[9:7], addr[6:4]);
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= 32'h00000000;
            if (addr[11:8] == 4'h0) begin
                case (addr)
                    ADDR_CTRL:   rdata <= ctrl;
                    ADDR_ENABLE: rdata <= {24'h000000, enable};
                    ADDR_FORCE:  rdata <= {16'h0000, forcedCond};
                    ADDR_UVBLK:  rdata <= {18'h00000, uvSet};
                    ADDR_STATUS: rdata <= {8'h00, blockedOut, tripOut,
                                           startOut};
                    ADDR_FREQ:   rdata <= {18'h00000, freq};
                    ADDR_EVCNT:  rdata <= eventTotal;
                    default:     rdata <= 32'h00000000;
                endcase
            end else if (addr[11:8] == PAGE_STAGE) begin
                case (addr[3:2])
                    2'h0: rdata <= {30'h00000000,        // RULE14
                        tripOut[rdStage] ? COND_TRIP
                      : startOut[rdStage] ? COND_START
                      : blockedOut[rdStage] ? COND_BLOCKED
                      : COND_NORMAL};
                    2'h1: rdata <= {17'h00000, ratioMem[rdStage]};
                    2'h2: rdata <= {13'h0000,            // RULE16
                        delayMem[cfgIndex(group, rdStage)]};
                    default: rdata <= {{12{remainMem[rdStage][19]}},
                        remainMem[rdStage]};
                endcase
            end else if (addr[11:10] == {1'b0, PAGE_GROUP}) begin
                if (addr[3:2] == 2'h0) begin
                    rdata <= {usedMem[rdCfg], 17'h00000, thrMem[rdCfg]};
                end else if (addr[3:2] == 2'h1) begin
                    rdata <= {13'h0000, delayMem[rdCfg]};
                end
            end else if (addr[11:8] == PAGE_LOG && !addr[7]
                         && rdLog < 4'(LOG_DEPTH)) begin
                rdata <= addr[2] ? logInfo[rdLog] : logStamp[rdLog];
            end
        end
    end

endmodule

// ==== sim/frqp_stages_asserts.sv ====
`timescale 1ns/10ps
module frqp_stages_chk
    import frqp_pkg::*;
#(
    parameter int TICK_CYCLES_P = 20
)(
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              rd,
    input wire logic [31:0]       rdata,
    // stage status
    input wire logic [7:0]        startOut,
    input wire logic [7:0]        tripOut,
    input wire logic [7:0]        blockedOut,
    input wire logic              testMode,
    input wire logic              eventPulse
);
    logic [23:0] prevFlags;
    logic [7:0]  chg;
    logic        allZero;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // flags of every stage one cycle back
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prevFlags <= 24'h000000;
        end else begin
            prevFlags <= {blockedOut, tripOut, startOut};
        end
    end

    // stages whose flags moved, and a quiet-output flag
    assign chg = (startOut ^ prevFlags[7:0]) | (tripOut ^ prevFlags[15:8])
               | (blockedOut ^ prevFlags[23:16]);
    assign allZero = ({startOut, tripOut, blockedOut} == 24'h000000)
                   && !testMode && !eventPulse;

    a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> allZero)
        else $error("outputs active during reset");
    a_release_quiet: assert property (disable iff (1'b0)
        $rose(rstn) |-> allZero [*2]) else $error("outputs early after reset");
    a_blocked_alone: assert property (
        (blockedOut & (startOut | tripOut)) == 8'h00)
        else $error("blocked shown with start or trip");
    a_one_stage: assert property ($onehot0(chg))
        else $error("two stages updated in one cycle");
    for (genvar i = 0; i < 8; i++) begin : g_stage
        a_scan_spacing: assert property (chg[i] |=> !chg[i] [*8])
            else $error("stage updated twice within one scan");
    end
    a_event_follows: assert property (chg != 8'h00 |-> ##[0:2] eventPulse)
        else $error("flag change without event");
    a_rdata_holds: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        rd && addr == 12'h01C |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");

    // main scenarios reached
    c_trip: cover property ($rose(tripOut[0]));
    c_blocked: cover property ($rose(blockedOut[4]));
    c_test: cover property ($rose(testMode));
endmodule

bind frqp_stages frqp_stages_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
    .clk(clk), .rstn(rstn), .addr(addr), .rd(rd), .rdata(rdata),
    .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
    .testMode(testMode), .eventPulse(eventPulse));

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb
    import frqp_pkg::*;
;
    localparam int TCK = 20;
    logic              clk = 1'b0;
    logic              rstn = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    logic [FREQ_W-1:0] freqRef1;
    logic [FREQ_W-1:0] freqRef2;
    logic [FREQ_W-1:0] freqRef3;
    logic [VOLT_W-1:0] voltage;
    logic [7:0]        blockIn;
    logic [7:0]        startOut;
    logic [7:0]        tripOut;
    logic [7:0]        blockedOut;
    logic              testMode;
    logic              eventPulse;
    logic              rdLast = 1'b0;
    logic [31:0]       expQ[$];
    logic [11:0]       addrQ[$];
    int                n_errors = 0;
    int                n_compared = 0;

    frqp_stages #(.TICK_CYCLES_P(TCK)) uut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .freqRef1(freqRef1), .freqRef2(freqRef2),
        .freqRef3(freqRef3), .voltage(voltage), .blockIn(blockIn),
        .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
        .testMode(testMode), .eventPulse(eventPulse));

    // 10 MHz clock
    always #50 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (expQ.size() != 0) n_errors++;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one-cycle write, then an idle cycle
    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // one-cycle read with its expected word noted
    task automatic rdExp(input logic [11:0] a, input logic [31:0] e);
        expQ.push_back(e);
        addrQ.push_back(a);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic waitTicks(input int n);
        repeat (n * TCK) @(posedge clk);
    endtask

    // read data stands in the cycle after the strobe
    always @(posedge clk) rdLast <= rd;
    always @(negedge clk) begin
        if (rdLast) begin
            check(rdata, expQ.pop_front(),
                  $sformatf("reg %h", addrQ.pop_front()));
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("timeout");
        tally_and_finish();
    end

    // main sequence
    initial begin
        // falling edge at time zero so the async reset acts at once
        rstn <= 1'b0;
        addr = 12'h000;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
        freqRef1 = 14'h1388;
        freqRef2 = 14'h1388;
        freqRef3 = 14'h1388;
        voltage = 14'h2710;
        blockIn = 8'h00;
        void'($urandom(32'hC6D2));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values
        rdExp(ADDR_CTRL, CTRL_RST);
        rdExp(ADDR_ENABLE, 32'h00000000);
        rdExp(ADDR_FORCE, 32'h00000000);
        rdExp(ADDR_UVBLK, 32'h00000000);
        rdExp(12'h400, 32'h000013EC);
        rdExp(12'h440, 32'h00001324);
        rdExp(12'h404, 32'h00000008);
        rdExp(12'h01C, 32'h00000000);
        // over stage 0: unused, then used, start, trip
        wrReg(ADDR_ENABLE, 32'h000000FF);
        freqRef1 <= 14'(32'h13ED + $urandom % 32'h1F4);
        waitTicks(3);
        rdExp(12'h100, 32'(COND_NORMAL));
        wrReg(12'h400, 32'h800013EC);
        waitTicks(3);
        rdExp(12'h100, 32'(COND_START));
        rdExp(ADDR_STATUS, 32'h00000001);
        waitTicks(8);
        rdExp(12'h100, 32'(COND_TRIP));
        rdExp(12'h108, 32'h00000008);
        rdExp(12'h10C, 32'h00000000);
        // release needs the full hysteresis
        freqRef1 <= 14'h13EB;
        waitTicks(3);
        rdExp(12'h100, 32'(COND_TRIP));
        freqRef1 <= 14'h13EA;
        waitTicks(3);
        rdExp(12'h100, 32'(COND_NORMAL));
        freqRef1 <= 14'h15EA;
        waitTicks(2);
        rdExp(12'h104, 32'h0000044C);
        // every reference selection
        freqRef1 <= 14'h1388;
        freqRef2 <= 14'h1770;
        freqRef3 <= 14'h13BA;
        for (int r = 0; r < 4; r++) begin
            wrReg(ADDR_CTRL, 32'(r) << CTRL_REF_LSB);
            waitTicks(2);
            rdExp(ADDR_FREQ, r == 1 ? 32'h1770 :
                  (r == 2 ? 32'h13BA : 32'h1388));
        end
        wrReg(ADDR_CTRL, 32'h00000000);
        // under stage 4 with long delay, then undervoltage block
        wrReg(12'h444, 32'h000003E8);
        wrReg(12'h440, 32'h80001324);
        freqRef1 <= 14'(32'hFA0 + $urandom % 32'h384);
        waitTicks(3);
        rdExp(12'h140, 32'(COND_START));
        rdExp(12'h148, 32'h000003E8);
        voltage <= 14'h0FA0;
        wrReg(ADDR_UVBLK, 32'h00001388);
        waitTicks(3);
        rdExp(12'h140, 32'(COND_BLOCKED));
        rdExp(ADDR_STATUS, 32'h00100000);
        voltage <= 14'h2710;
        waitTicks(3);
        rdExp(12'h140, 32'(COND_START));
        // blocking input
        blockIn <= 8'h10;
        waitTicks(3);
        rdExp(12'h140, 32'(COND_BLOCKED));
        blockIn <= 8'h00;
        waitTicks(3);
        rdExp(12'h140, 32'(COND_START));
        // every node operating mode
        for (int m = 0; m < 5; m++) begin
            wrReg(ADDR_CTRL, 32'(m));
            waitTicks(3);
            rdExp(12'h140, m == 4 ? 32'h0 : (m[0] ? 32'h3 : 32'h1));
            check(32'(testMode), 32'(m == 2 || m == 3), "testMode");
        end
        // setting group switch keeps general settings
        wrReg(ADDR_CTRL, 32'h00000100);
        waitTicks(3);
        rdExp(12'h140, 32'(COND_NORMAL));
        rdExp(ADDR_ENABLE, 32'h000000FF);
        wrReg(ADDR_CTRL, 32'h00000000);
        waitTicks(3);
        rdExp(12'h140, 32'(COND_START));
        // every forced status on stage 0
        wrReg(ADDR_CTRL, 32'h00001000);
        for (int c = 0; c < 4; c++) begin
            wrReg(ADDR_FORCE, 32'(c));
            waitTicks(2);
            rdExp(12'h100, 32'(c));
        end
        // disabled stages stay silent even when forced
        wrReg(ADDR_ENABLE, 32'h000000EE);
        waitTicks(2);
        rdExp(12'h100, 32'(COND_NORMAL));
        rdExp(ADDR_STATUS, 32'h00000000);
        wrReg(ADDR_EVCNT, 32'h00000000);
        rdExp(ADDR_EVCNT, 32'h00000000);
        // re-enabled forced stage gives exactly one event
        wrReg(ADDR_ENABLE, 32'h000000EF);
        waitTicks(2);
        rdExp(ADDR_EVCNT, 32'h00000001);
        check(32'(blockedOut), 32'h00000001, "blockedOut");
        check(32'({tripOut, startOut}), 32'h00000000, "tripStart");
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule
